/* dv/tb_top.sv */
// Self-checking bench for the flash command index and fault configuration slice.
// Assumes fcifc_top with IDX_W of 3 and the register map in fcifc_params.svh.
`timescale 1ns/100ps
`default_nettype none
`include "fcifc_params.svh"

module tb_top;
	logic clk, rst_n, wr_s, rd_s, done, ard, sf, df;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] idx;
	logic cap, irq;
	int fails, check_count, cyc;

	fcifc_top #(.IDX_W(3)) dut_u (
		.CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr_s), .RD_IN(rd_s), .CMD_DONE_IN(done), .ARRAY_RD_IN(ard),
		.SINGLE_FAULT_IN(sf), .DOUBLE_FAULT_IN(df), .RDATA_OUT(rdata),
		.CMD_WORD_INDEX_OUT(idx), .ECC_CAPTURE_OUT(cap), .IRQ_OUT(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task stop_test;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// Generous ceiling: the whole sequence needs under two hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			stop_test();
		end
	end

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe edge
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, rdata);
	endtask : rd

	task arr(input logic s, input logic d, input logic ecap);
		@(posedge clk);
		ard <= 1'b1;
		sf <= s;
		df <= d;
		@(posedge clk);
		ard <= 1'b0;
		sf <= 1'b0;
		df <= 1'b0;
		#1 chk("capture", {7'h00, ecap}, {7'h00, cap});
	endtask : arr

	task irqchk(input logic e);
		@(posedge clk);
		#1 chk("irq", {7'h00, e}, {7'h00, irq});
	endtask : irqchk

	task t_reset;
		rd(`FCIFC_OFF_INDEX, 8'h00);
		rd(`FCIFC_OFF_CONFIG, 8'h00);
		rd(`FCIFC_OFF_FLT_ST, 8'h00);
		chk("index", 8'h00, {5'h00, idx});
		chk("irq", 8'h00, {7'h00, irq});
		$display("reset test done");
	endtask : t_reset

	task t_regs;
		wr(`FCIFC_OFF_INDEX, 8'hff);
		rd(`FCIFC_OFF_INDEX, 8'h07);
		chk("index", 8'h07, {5'h00, idx});
		wr(`FCIFC_OFF_INDEX, 8'h05);
		#1 chk("index", 8'h05, {5'h00, idx});
		wr(`FCIFC_OFF_CONFIG, 8'hff);
		rd(`FCIFC_OFF_CONFIG, 8'h93);
		wr(`FCIFC_OFF_CONFIG, 8'h00);
		wr(`FCIFC_OFF_RSV, 8'hff);
		rd(`FCIFC_OFF_RSV, 8'h00);
		wr(8'h01, 8'hff);
		rd(8'h01, 8'h00);
		rd(`FCIFC_OFF_INDEX, 8'h05);
		$display("register test done");
	endtask : t_regs

	task t_done_irq;
		@(posedge clk);
		done <= 1'b1;
		irqchk(1'b0);
		irqchk(1'b0);
		rd(`FCIFC_OFF_STATUS, 8'h80);
		wr(`FCIFC_OFF_CONFIG, 8'h80);
		irqchk(1'b1);
		@(posedge clk);
		done <= 1'b0;
		irqchk(1'b0);
		irqchk(1'b0);
		rd(`FCIFC_OFF_STATUS, 8'h00);
		wr(`FCIFC_OFF_CONFIG, 8'h00);
		$display("done interrupt test done");
	endtask : t_done_irq

	task t_force_double;
		wr(`FCIFC_OFF_FLT_IE, 8'h02);
		wr(`FCIFC_OFF_CONFIG, 8'h02);
		arr(1'b0, 1'b0, 1'b0);
		irqchk(1'b1);
		rd(`FCIFC_OFF_FLT_ST, 8'h02);
		wr(`FCIFC_OFF_FLT_ST, 8'h02);
		irqchk(1'b0);
		rd(`FCIFC_OFF_CONFIG, 8'h02);
		arr(1'b0, 1'b1, 1'b1);
		rd(`FCIFC_OFF_FLT_ST, 8'h02);
		wr(`FCIFC_OFF_CONFIG, 8'h00);
		wr(`FCIFC_OFF_FLT_ST, 8'h03);
		$display("forced double test done");
	endtask : t_force_double

	task t_force_single;
		wr(`FCIFC_OFF_FLT_IE, 8'h00);
		wr(`FCIFC_OFF_CONFIG, 8'h01);
		arr(1'b0, 1'b0, 1'b0);
		irqchk(1'b0);
		rd(`FCIFC_OFF_FLT_ST, 8'h01);
		wr(`FCIFC_OFF_FLT_IE, 8'h01);
		irqchk(1'b1);
		rd(`FCIFC_OFF_CONFIG, 8'h01);
		wr(`FCIFC_OFF_FLT_ST, 8'h01);
		irqchk(1'b0);
		arr(1'b1, 1'b0, 1'b1);
		rd(`FCIFC_OFF_FLT_ST, 8'h01);
		wr(`FCIFC_OFF_CONFIG, 8'h00);
		wr(`FCIFC_OFF_FLT_ST, 8'h03);
		$display("forced single test done");
	endtask : t_force_single

	task t_real;
		wr(`FCIFC_OFF_FLT_IE, 8'h03);
		wr(`FCIFC_OFF_CONFIG, 8'h10);
		arr(1'b1, 1'b0, 1'b0);
		irqchk(1'b0);
		rd(`FCIFC_OFF_FLT_ST, 8'h00);
		wr(`FCIFC_OFF_CONFIG, 8'h00);
		arr(1'b0, 1'b0, 1'b0);
		rd(`FCIFC_OFF_FLT_ST, 8'h00);
		arr(1'b1, 1'b0, 1'b1);
		rd(`FCIFC_OFF_FLT_ST, 8'h01);
		wr(`FCIFC_OFF_FLT_ST, 8'h01);
		arr(1'b0, 1'b1, 1'b1);
		irqchk(1'b1);
		rd(`FCIFC_OFF_FLT_ST, 8'h02);
		wr(`FCIFC_OFF_FLT_ST, 8'h02);
		irqchk(1'b0);
		$display("real fault test done");
	endtask : t_real

	// Reset in mid-run must wipe state that was really set beforehand
	task t_mid_reset;
		wr(`FCIFC_OFF_INDEX, 8'h06);
		wr(`FCIFC_OFF_CONFIG, 8'h93);
		wr(`FCIFC_OFF_FLT_IE, 8'h03);
		rd(`FCIFC_OFF_FLT_IE, 8'h03);
		arr(1'b0, 1'b0, 1'b0);
		irqchk(1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("irq", 8'h00, {7'h00, irq});
		rd(`FCIFC_OFF_INDEX, 8'h00);
		rd(`FCIFC_OFF_CONFIG, 8'h00);
		rd(`FCIFC_OFF_FLT_IE, 8'h00);
		rd(`FCIFC_OFF_FLT_ST, 8'h00);
		$display("mid-run reset test done");
	endtask : t_mid_reset

	initial begin
		fails = 0;
		check_count = 0;
		cyc = 0;
		rst_n = 1'b0;
		{wr_s, rd_s, done, ard, sf, df} = 6'h00;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_done_irq();
		t_force_double();
		t_force_single();
		t_real();
		t_mid_reset();
		stop_test();
	end
endmodule : tb_top

`default_nettype wire

/* inc/fcifc_fault_if.sv */
// Carries array read events, fault sources and fault decisions between the
// register slice and the fault event generator. Single clock domain.
`timescale 1ns/100ps
`default_nettype none

interface fcifc_fault_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic array_rd;
	logic single_real;
	logic double_real;
	logic force_single;
	logic force_double;
	logic ignore_single;
	logic set_single;
	logic set_double;
	logic capture;

	modport ctrl (
		input clk, rst_n, set_single, set_double, capture,
		output array_rd, single_real, double_real, force_single, force_double, ignore_single
	);
	modport gen (
		input clk, rst_n, array_rd, single_real, double_real, force_single, force_double, ignore_single,
		output set_single, set_double, capture
	);
endinterface : fcifc_fault_if

`default_nettype wire

/* inc/fcifc_params.svh */
// Constants for the flash command index and fault configuration slice.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef FCIFC_PARAMS_SVH
`define FCIFC_PARAMS_SVH

// Register offsets
`define FCIFC_OFF_INDEX 8'h02
`define FCIFC_OFF_CONFIG 8'h04
`define FCIFC_OFF_FLT_IE 8'h05
`define FCIFC_OFF_STATUS 8'h06
`define FCIFC_OFF_FLT_ST 8'h07
`define FCIFC_OFF_RSV 8'h0c

// Field positions in the configuration register
`define FCIFC_CFG_DONE_IE 7
`define FCIFC_CFG_IGN_SF 4
`define FCIFC_CFG_FORCE_DF 1
`define FCIFC_CFG_FORCE_SF 0

// Field positions shared by fault enable and fault status registers
`define FCIFC_FLT_DOUBLE 1
`define FCIFC_FLT_SINGLE 0

// Field position of the done flag in the status register
`define FCIFC_ST_DONE 7

// Reset values
`define FCIFC_RST_INDEX 8'h00
`define FCIFC_RST_CONFIG 4'h0
`define FCIFC_RST_FLT_IE 2'h0
`define FCIFC_RST_RDATA 8'h00

`endif

/* inc/fcifc_pkg.sv */
// Types for the flash command index and fault configuration slice.
// Assumes fcifc_params.svh supplies the numeric constants.
package fcifc_pkg;

	// Register selected by the current address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_INDEX,
		SEL_CONFIG,
		SEL_FLT_IE,
		SEL_STATUS,
		SEL_FLT_ST,
		SEL_RSV
	} fcifc_reg_type;

	// Writable configuration bits
	typedef struct packed {
		logic done_ie;
		logic ign_sf;
		logic force_df;
		logic force_sf;
	} fcifc_cfg_type;

endpackage : fcifc_pkg

/* verilog/fcifc_fault_gen.sv */
// Decides which fault flags an array read sets and whether capture updates.
// Assumes array_rd is a one-cycle pulse per completed array read.
`timescale 1ns/100ps
`default_nettype none

module fcifc_fault_gen (
	fcifc_fault_if.gen flt
);
	wire logic single_seen;

	// Suppression hides only real single faults
	assign single_seen = flt.single_real & ~flt.ignore_single;

	// Forced or reported real single fault
	assign flt.set_single = flt.array_rd & (single_seen | flt.force_single);

	assign flt.set_double = flt.array_rd & (flt.double_real | flt.force_double);

	// Capture follows real faults only, never forcing
	assign flt.capture = flt.array_rd & (flt.double_real | single_seen);

	a_forced_no_capture: assert property (@(posedge flt.clk) disable iff (!flt.rst_n)
		flt.array_rd && (flt.force_double || flt.force_single) && !flt.double_real && !flt.single_real
		|-> !flt.capture)
		else $error("capture moved on a forced fault");

	a_real_only_single: assert property (@(posedge flt.clk) disable iff (!flt.rst_n)
		flt.set_single |-> flt.force_single || (flt.single_real && !flt.ignore_single))
		else $error("single flag set without cause");

endmodule : fcifc_fault_gen

`default_nettype wire

/* verilog/fcifc_sticky_bit.sv */
// One sticky event flag, set by hardware and cleared by software.
// Assumes set and clear are synchronous one-cycle terms.
`timescale 1ns/100ps
`default_nettype none

module fcifc_sticky_bit (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic set_in,
	input wire logic clr_in,
	output logic flag_out
);
	logic flag_d;

	// A set landing on the clearing write is kept
	assign flag_d = set_in | (flag_out & ~clr_in);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= 1'b0;
		end else begin
			flag_out <= flag_d;
		end
	end

	a_set_wins_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		set_in |=> flag_out)
		else $error("sticky flag lost a set event");

	a_clear_drops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		clr_in && !set_in |=> !flag_out)
		else $error("sticky flag ignored a clear");

endmodule : fcifc_sticky_bit

`default_nettype wire

/* verilog/fcifc_top.sv */
// Register slice: command word index, reserved test register, flash
// configuration, fault enables and fault status with one interrupt line.
// Assumes the register port master holds strobes for one cycle, never both.
`timescale 1ns/100ps
`default_nettype none
`include "fcifc_params.svh"

// How it works
// - The index register picks which command array word host accesses reach.
// - Only the index bits read back; upper index bits read zero.
// - Reserved test register reads zero and ignores writes.
// - Config keeps done enable, suppress, force double, force single only.
// - Done enable plus done flag raises the interrupt; otherwise no done interrupt.
// - Suppress stops real single faults from setting the flag or interrupting.
// - Without suppress every real single fault sets the single flag.
// - Force double makes every array read set the double flag.
// - Without force double, only real double faults set the double flag.
// - Force double stays until software writes zero.
// - Forced double faults leave the capture registers untouched.
// - Force single makes every array read set the single flag.
// - Without force single, only real single faults set the single flag.
// - Force single stays until software writes zero.
// - Forced single faults leave the capture registers untouched.
// - Done flag is high after completion, low while a command runs.
// - Double enable plus double flag raises the interrupt.
module fcifc_top #(
	parameter int IDX_W = 3
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic CMD_DONE_IN,
	input wire logic ARRAY_RD_IN,
	input wire logic SINGLE_FAULT_IN,
	input wire logic DOUBLE_FAULT_IN,
	output logic [7:0] RDATA_OUT,
	output logic [IDX_W-1:0] CMD_WORD_INDEX_OUT,
	output logic ECC_CAPTURE_OUT,
	output logic IRQ_OUT
);
	fcifc_pkg::fcifc_reg_type sel;
	fcifc_pkg::fcifc_cfg_type cfg_q;
	fcifc_pkg::fcifc_cfg_type cfg_d;
	logic [1:0] flt_ie_q;
	logic [7:0] rdata_d;
	logic irq_d;
	wire logic wr_index;
	wire logic wr_config;
	wire logic wr_flt_ie;
	wire logic wr_flt_st;
	wire logic clr_single;
	wire logic clr_double;
	wire logic single_flag;
	wire logic double_flag;
	wire logic [7:0] index_rd;
	wire logic [7:0] config_rd;
	wire logic [7:0] flt_ie_rd;
	wire logic [7:0] flt_st_rd;
	wire logic [7:0] status_rd;

	fcifc_fault_if flt (
		.clk(CLK_IN),
		.rst_n(RESETN_IN)
	);

	// Address decode
	assign sel = (ADDR_IN == `FCIFC_OFF_INDEX) ? fcifc_pkg::SEL_INDEX :
		(ADDR_IN == `FCIFC_OFF_CONFIG) ? fcifc_pkg::SEL_CONFIG :
		(ADDR_IN == `FCIFC_OFF_FLT_IE) ? fcifc_pkg::SEL_FLT_IE :
		(ADDR_IN == `FCIFC_OFF_STATUS) ? fcifc_pkg::SEL_STATUS :
		(ADDR_IN == `FCIFC_OFF_FLT_ST) ? fcifc_pkg::SEL_FLT_ST :
		(ADDR_IN == `FCIFC_OFF_RSV) ? fcifc_pkg::SEL_RSV :
		fcifc_pkg::SEL_NONE;

	// Reserved register has no write path at all
	assign wr_index = WR_IN && sel == fcifc_pkg::SEL_INDEX;
	assign wr_config = WR_IN && sel == fcifc_pkg::SEL_CONFIG;
	assign wr_flt_ie = WR_IN && sel == fcifc_pkg::SEL_FLT_IE;
	assign wr_flt_st = WR_IN && sel == fcifc_pkg::SEL_FLT_ST;

	// Fault status clears by writing a one
	assign clr_single = wr_flt_st & WDATA_IN[`FCIFC_FLT_SINGLE];
	assign clr_double = wr_flt_st & WDATA_IN[`FCIFC_FLT_DOUBLE];

	// Only the four assigned bits are stored
	assign cfg_d.done_ie = WDATA_IN[`FCIFC_CFG_DONE_IE];
	assign cfg_d.ign_sf = WDATA_IN[`FCIFC_CFG_IGN_SF];
	assign cfg_d.force_df = WDATA_IN[`FCIFC_CFG_FORCE_DF];
	assign cfg_d.force_sf = WDATA_IN[`FCIFC_CFG_FORCE_SF];

	assign index_rd = {{(8 - IDX_W){1'b0}}, CMD_WORD_INDEX_OUT};

	assign config_rd = ({7'h00, cfg_q.done_ie} << `FCIFC_CFG_DONE_IE) |
		({7'h00, cfg_q.ign_sf} << `FCIFC_CFG_IGN_SF) |
		({7'h00, cfg_q.force_df} << `FCIFC_CFG_FORCE_DF) |
		({7'h00, cfg_q.force_sf} << `FCIFC_CFG_FORCE_SF);

	assign flt_ie_rd = ({7'h00, flt_ie_q[1]} << `FCIFC_FLT_DOUBLE) |
		({7'h00, flt_ie_q[0]} << `FCIFC_FLT_SINGLE);

	assign flt_st_rd = ({7'h00, double_flag} << `FCIFC_FLT_DOUBLE) |
		({7'h00, single_flag} << `FCIFC_FLT_SINGLE);

	// Done flag comes straight from the command sequencer
	assign status_rd = {7'h00, CMD_DONE_IN} << `FCIFC_ST_DONE;

	// Read mux; unmapped addresses and the reserved register read zero
	always_comb begin
		rdata_d = 8'h00;
		if (RD_IN) begin
			case (sel)
				fcifc_pkg::SEL_INDEX: rdata_d = index_rd;
				fcifc_pkg::SEL_CONFIG: rdata_d = config_rd;
				fcifc_pkg::SEL_FLT_IE: rdata_d = flt_ie_rd;
				fcifc_pkg::SEL_STATUS: rdata_d = status_rd;
				fcifc_pkg::SEL_FLT_ST: rdata_d = flt_st_rd;
				fcifc_pkg::SEL_RSV: rdata_d = 8'h00;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Enabled done and unmasked fault flags drive one level line
	assign irq_d = (cfg_q.done_ie & CMD_DONE_IN) |
		(flt_ie_q[`FCIFC_FLT_SINGLE] & single_flag) |
		(flt_ie_q[`FCIFC_FLT_DOUBLE] & double_flag);

	// Fault generator hookup
	assign flt.array_rd = ARRAY_RD_IN;
	assign flt.single_real = SINGLE_FAULT_IN;
	assign flt.double_real = DOUBLE_FAULT_IN;
	assign flt.force_single = cfg_q.force_sf;
	assign flt.force_double = cfg_q.force_df;
	assign flt.ignore_single = cfg_q.ign_sf;

	fcifc_fault_gen u_fault_gen (
		.flt(flt.gen)
	);

	fcifc_sticky_bit u_single_flag (
		.clk_in(CLK_IN),
		.rst_n_in(RESETN_IN),
		.set_in(flt.set_single),
		.clr_in(clr_single),
		.flag_out(single_flag)
	);

	fcifc_sticky_bit u_double_flag (
		.clk_in(CLK_IN),
		.rst_n_in(RESETN_IN),
		.set_in(flt.set_double),
		.clr_in(clr_double),
		.flag_out(double_flag)
	);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			CMD_WORD_INDEX_OUT <= IDX_W'(`FCIFC_RST_INDEX);
		end else if (wr_index) begin
			CMD_WORD_INDEX_OUT <= WDATA_IN[IDX_W-1:0];
		end
	end

	// Forces change only by a software write
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cfg_q <= `FCIFC_RST_CONFIG;
		end else if (wr_config) begin
			cfg_q <= cfg_d;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			flt_ie_q <= `FCIFC_RST_FLT_IE;
		end else if (wr_flt_ie) begin
			flt_ie_q <= {WDATA_IN[`FCIFC_FLT_DOUBLE], WDATA_IN[`FCIFC_FLT_SINGLE]};
		end
	end

	// Registered outputs; read data stand one cycle only
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			RDATA_OUT <= `FCIFC_RST_RDATA;
			IRQ_OUT <= 1'b0;
			ECC_CAPTURE_OUT <= 1'b0;
		end else begin
			RDATA_OUT <= rdata_d;
			IRQ_OUT <= irq_d;
			ECC_CAPTURE_OUT <= flt.capture;
		end
	end

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	sequence s_read(logic [7:0] off);
		RD_IN && ADDR_IN == off;
	endsequence

	sequence s_write(logic [7:0] off);
		WR_IN && ADDR_IN == off;
	endsequence

	a_index_write: assert property (
		s_write(`FCIFC_OFF_INDEX) |=> CMD_WORD_INDEX_OUT == $past(WDATA_IN[IDX_W-1:0]))
		else $error("index write not taken");

	a_index_readback: assert property (
		s_read(`FCIFC_OFF_INDEX) |=> RDATA_OUT == {{(8 - IDX_W){1'b0}}, $past(CMD_WORD_INDEX_OUT)})
		else $error("index read wrong");

	a_reserved_zero: assert property (
		s_read(`FCIFC_OFF_RSV) |=> RDATA_OUT == 8'h00)
		else $error("reserved register not zero");

	a_config_layout: assert property (
		s_write(`FCIFC_OFF_CONFIG) ##1 s_read(`FCIFC_OFF_CONFIG) |=> RDATA_OUT == ($past(WDATA_IN, 2) & 8'h93))
		else $error("configuration readback wrong");

	a_read_one_cycle: assert property (
		!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data held past one cycle");

	a_done_irq: assert property (
		cfg_q.done_ie && CMD_DONE_IN |=> IRQ_OUT)
		else $error("done interrupt missing");

	a_irq_quiet: assert property (
		!(cfg_q.done_ie && CMD_DONE_IN) && !(flt_ie_q[1] && double_flag) && !(flt_ie_q[0] && single_flag)
		|=> !IRQ_OUT)
		else $error("interrupt without an enabled cause");

	a_ignore_single: assert property (
		ARRAY_RD_IN && cfg_q.ign_sf && !cfg_q.force_sf && !single_flag |=> !single_flag)
		else $error("suppressed single fault was reported");

	a_report_single: assert property (
		ARRAY_RD_IN && SINGLE_FAULT_IN && !cfg_q.ign_sf |=> single_flag)
		else $error("single fault not reported");

	a_force_double: assert property (
		ARRAY_RD_IN && cfg_q.force_df && flt_ie_q[1] |=> double_flag ##1 IRQ_OUT)
		else $error("forced double fault did not interrupt");

	a_real_double: assert property (
		ARRAY_RD_IN && !cfg_q.force_df && !DOUBLE_FAULT_IN && !double_flag |=> !double_flag)
		else $error("double flag set without cause");

	a_force_hold: assert property (
		!wr_config |=> $stable(cfg_q.force_df) && $stable(cfg_q.force_sf))
		else $error("force bit changed without a write");

	a_forced_capture: assert property (
		ARRAY_RD_IN && cfg_q.force_sf && !SINGLE_FAULT_IN && !DOUBLE_FAULT_IN |=> !ECC_CAPTURE_OUT)
		else $error("capture updated on forced single fault");

	a_force_single: assert property (
		ARRAY_RD_IN && cfg_q.force_sf |=> single_flag)
		else $error("forced single fault not flagged");

	a_done_status: assert property (
		s_read(`FCIFC_OFF_STATUS) |=> RDATA_OUT[`FCIFC_ST_DONE] == $past(CMD_DONE_IN))
		else $error("done flag read wrong");

	a_double_irq: assert property (
		double_flag && flt_ie_q[1] |=> IRQ_OUT)
		else $error("double fault interrupt missing");

	a_index_hold: assert property (
		!wr_index |=> $stable(CMD_WORD_INDEX_OUT))
		else $error("index changed without a write");

	a_index_upper: assert property (
		s_read(`FCIFC_OFF_INDEX) |=> RDATA_OUT[7:IDX_W] == '0)
		else $error("upper index bits not zero");

	a_reserved_inert: assert property (
		s_write(`FCIFC_OFF_RSV) |=> $stable(cfg_q) && $stable(flt_ie_q) && $stable(CMD_WORD_INDEX_OUT))
		else $error("reserved write changed a register");

	a_config_spare: assert property (
		s_read(`FCIFC_OFF_CONFIG) |=> (RDATA_OUT & 8'h6c) == 8'h00)
		else $error("unassigned configuration bits not zero");

	a_done_gated: assert property (
		!cfg_q.done_ie && !single_flag && !double_flag |=> !IRQ_OUT)
		else $error("done interrupt while disabled");

	a_ignore_capture: assert property (
		ARRAY_RD_IN && SINGLE_FAULT_IN && !DOUBLE_FAULT_IN && cfg_q.ign_sf |=> !ECC_CAPTURE_OUT)
		else $error("suppressed single fault captured");

	a_report_capture: assert property (
		ARRAY_RD_IN && SINGLE_FAULT_IN && !cfg_q.ign_sf |=> ECC_CAPTURE_OUT)
		else $error("reported single fault not captured");

	a_double_sticky: assert property (
		double_flag && !clr_double |=> double_flag)
		else $error("double flag dropped without a clear");

	a_real_double_set: assert property (
		ARRAY_RD_IN && DOUBLE_FAULT_IN |=> double_flag)
		else $error("real double fault not flagged");

	a_force_df_clear: assert property (
		wr_config && !WDATA_IN[`FCIFC_CFG_FORCE_DF] |=> !cfg_q.force_df)
		else $error("force double not cleared by write");

	a_double_capture: assert property (
		ARRAY_RD_IN && DOUBLE_FAULT_IN |=> ECC_CAPTURE_OUT)
		else $error("real double fault not captured");

	a_df_no_capture: assert property (
		ARRAY_RD_IN && cfg_q.force_df && !SINGLE_FAULT_IN && !DOUBLE_FAULT_IN |=> !ECC_CAPTURE_OUT)
		else $error("capture updated on forced double fault");

	a_force_single_irq: assert property (
		ARRAY_RD_IN && cfg_q.force_sf && flt_ie_q[0] |=> single_flag ##1 IRQ_OUT)
		else $error("forced single fault did not interrupt");

	a_real_single_only: assert property (
		ARRAY_RD_IN && !cfg_q.force_sf && !SINGLE_FAULT_IN && !single_flag |=> !single_flag)
		else $error("single flag set without cause");

	a_force_sf_clear: assert property (
		wr_config && !WDATA_IN[`FCIFC_CFG_FORCE_SF] |=> !cfg_q.force_sf)
		else $error("force single not cleared by write");

	a_single_irq: assert property (
		single_flag && flt_ie_q[0] |=> IRQ_OUT)
		else $error("single fault interrupt missing");

	a_reset_clear: assert property (disable iff (1'b0)
		!RESETN_IN |-> CMD_WORD_INDEX_OUT == '0 && cfg_q == '0 && flt_ie_q == 2'h0 && !IRQ_OUT)
		else $error("reset left state behind");

endmodule : fcifc_top

`default_nettype wire
